// *** verif/fault_sel_props.sv ***
// concurrent checks on the fault selector top ports
// assumes one clock, sys_clk, with rst_b as async active-low reset
`timescale 1ns/1ps
`default_nettype none
module fault_sel_props (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// request side
	input wire logic        req_valid,
	input wire logic [3:0]  req_src,
	input wire logic [15:0] req_sel,
	input wire logic        req_present,
	input wire logic        req_executable,
	input wire logic        req_ext_event,
	input wire logic        req_idt_ref,
	input wire logic        ts_begin,
	input wire logic        ts_via_call,
	input wire logic        tr_loaded,
	input wire logic        backlink_ok,
	input wire logic        pf_delivering,
	input wire logic        deliver_done,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wr_data,
	input wire logic        reg_wr_en,
	// exception side
	input wire logic        exc_valid,
	input wire logic [7:0]  exc_vector,
	input wire logic [15:0] exc_err_code,
	input wire logic        exc_err_push,
	input wire logic [1:0]  exc_eip_sel,
	input wire logic        exc_new_ctx,
	input wire logic        exc_load_all,
	input wire logic        exc_restartable,
	input wire logic        seg_loaded,
	input wire logic        ts_committed
);
	// mirrors of mode, pending delivery and switch violation
	logic        legacy_q;
	logic        busy_q;
	logic        viol_q;
	logic [15:0] code_q;
	wire contrib = exc_valid && (exc_vector inside {8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D});
	wire busy    = busy_q || contrib;
	wire viol    = viol_q || (exc_valid && exc_load_all);
	wire calm    = !busy && !pf_delivering;
	// a raise seen in the cycle of handler entry counts as busy from that cycle on, held in busy_q until deliver_done clears busy_q
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			legacy_q <= 1'h0;
			busy_q   <= 1'h0;
			viol_q   <= 1'h0;
			code_q   <= 16'h0000;
		end else begin
			legacy_q <= (reg_wr_en && reg_addr == 8'h00) ? reg_wr_data[0] : legacy_q;
			busy_q   <= busy && !deliver_done;
			viol_q   <= viol && !ts_begin;
			code_q   <= {req_sel[15:2], req_idt_ref, req_ext_event};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	np_code_a: assert property (req_valid && req_src == 4'h0 && !req_present && calm |=>
		exc_valid && exc_vector == 8'h0B && exc_err_code == code_q && exc_err_push)
		else $error("not-present vector or code wrong");
	ss_fault_a: assert property (req_valid && req_src == 4'h1 && !req_present && calm |=>
		exc_valid && exc_vector == 8'h0C && exc_err_code == code_q)
		else $error("absent stack did not give stack fault");
	overrun_gp_a: assert property (req_valid && req_src == 4'hA && !legacy_q && calm |=>
		exc_valid && exc_vector == 8'h0D && exc_restartable)
		else $error("operand overrun not reported as protection fault");
	overrun_abort_a: assert property (req_valid && req_src == 4'hA && legacy_q |=>
		exc_valid && exc_vector == 8'h09 && !exc_err_push && !exc_restartable && exc_eip_sel == 2'h0)
		else $error("legacy overrun payload wrong");
	double_fault_a: assert property (req_valid && req_src == 4'h0 && !req_present && !calm |=>
		exc_valid && exc_vector == 8'h08 && exc_err_code == 16'h0000 && !exc_restartable)
		else $error("nested contributory fault not doubled");
	post_commit_a: assert property (ts_committed && req_valid && req_src == 4'h8 && !req_executable && !viol && calm
		|=> exc_valid && exc_vector == 8'h0A && exc_eip_sel == 2'h2 && exc_new_ctx && exc_load_all)
		else $error("post-commit fault payload wrong");
	unchecked_a: assert property (ts_committed && viol && req_valid && (req_src inside {4'h7, 4'h8, 4'h9})
		|=> !exc_valid && seg_loaded)
		else $error("load after a violation was checked");
	commit_a: assert property ($rose(ts_committed) |-> $past(tr_loaded)
		&& (!$past(ts_via_call) || $past(backlink_ok)))
		else $error("switch committed without its conditions");
endmodule : fault_sel_props
bind task_switch_segment_fault_checker fault_sel_props u_fault_sel_props (.*);
`default_nettype wire

// *** verif/tb_task_switch_segment_fault_checker.sv ***
// self-checking bench for the task switch and segment fault selector
// assumes design and checker compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_task_switch_segment_fault_checker;
	// request fields, in the order of the input concatenation in put
	typedef struct packed {
		logic [3:0]  src;
		logic [15:0] sel;
		logic        pres, lim, typ, wr, rd, ex, conf;
		logic [1:0]  dpriv, cpriv;
		logic        xev, itab;
		logic [31:0] tlim;
		logic        is32, busy, interrupt_return_instr;
	} rq_t;
	// design ports and bench counters
	logic        sys_clk, rst_b, req_valid, req_present, req_in_limit, req_type_ok, req_writable, req_readable;
	logic        req_executable, req_conforming, req_ext_event, req_idt_ref, tss_is32, tss_busy, ts_begin, ts_interrupt_return_instr;
	logic        ts_via_call, tr_loaded, backlink_ok, ts_end, pf_delivering, deliver_done, reg_wr_en, reg_rd_en;
	logic        exc_valid, exc_err_push, exc_new_ctx, exc_load_all, exc_restartable, exc_contrib, seg_loaded;
	logic        ts_committed;
	logic [1:0]  req_dpl, cur_cpl, exc_eip_sel;
	logic [3:0]  req_src;
	logic [7:0]  reg_addr, exc_vector;
	logic [15:0] req_sel, exc_err_code;
	logic [31:0] tss_limit, reg_wr_data, reg_rd_data;
	int          fail_count, checks_done, exp_cnt, cyc;
	task_switch_segment_fault_checker u_task_switch_segment_fault_checker (.*);
	function automatic rq_t dflt(input logic [3:0] s, input logic [15:0] sel);
		rq_t r;
		r = '0;
		{r.src, r.sel, r.pres, r.lim, r.typ, r.wr, r.rd, r.ex, r.is32} = {s, sel, 7'h7F};
		r.tlim = 32'h0000_0067;
		return r;
	endfunction : dflt
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic put(input rq_t r);
		{req_src, req_sel, req_present, req_in_limit, req_type_ok, req_writable, req_readable, req_executable,
			req_conforming, req_dpl, cur_cpl, req_ext_event, req_idt_ref, tss_limit, tss_is32, tss_busy, ts_interrupt_return_instr} <= r;
	endtask : put
	// code FFFF skips the code compare where no code is pushed
	task automatic fire(input rq_t r, input logic on, input logic [7:0] vec, input logic [15:0] code, input logic done);
		@(posedge sys_clk);
		put(r);
		req_valid <= 1'h1;
		@(posedge sys_clk);
		req_valid <= 1'h0;
		@(negedge sys_clk);
		chk("exc_valid", exc_valid, on);
		if (on) begin
			exp_cnt++;
			chk("vector", exc_vector, vec);
			if (code !== 16'hFFFF) chk("code", exc_err_code, code);
		end
		if (done) begin
			@(posedge sys_clk);
			deliver_done <= 1'h1;
			@(posedge sys_clk);
			deliver_done <= 1'h0;
		end
	endtask : fire
	task automatic ts_pulse(input logic [2:0] p);
		@(posedge sys_clk);
		{ts_begin, tr_loaded, ts_end} <= p;
		@(posedge sys_clk);
		{ts_begin, tr_loaded, ts_end} <= 3'h0;
	endtask : ts_pulse
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wr_data, reg_wr_en} <= {a, d, 1'h1};
		@(posedge sys_clk);
		reg_wr_en <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		{reg_addr, reg_rd_en} <= {a, 1'h1};
		@(posedge sys_clk);
		reg_rd_en <= 1'h0;
		@(negedge sys_clk);
		chk("rd_data", reg_rd_data, e);
	endtask : rd
	task automatic t_reset();
		chk("restartable", exc_restartable, 1'h1);
		chk("committed", ts_committed, 1'h0);
		rd(exc_pkg::REG_CTRL, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		wr(exc_pkg::REG_COUNT, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task automatic t_overrun();
		fire(dflt(4'hA, 16'h0030), 1'h1, 8'h0D, 16'h0030, 1'h1);
		chk("restartable", exc_restartable, 1'h1);
		wr(exc_pkg::REG_CTRL, 32'h0000_0001);
		rd(exc_pkg::REG_CTRL, 32'h0000_0001);
		fire(dflt(4'hA, 16'h0030), 1'h1, 8'h09, 16'hFFFF, 1'h1);
		chk("push_ptr", {exc_err_push, exc_eip_sel}, 3'h0);
		chk("restartable", exc_restartable, 1'h0);
		wr(exc_pkg::REG_CTRL, 32'h0000_0000);
		$display("overrun test done");
	endtask : t_overrun
	task automatic t_absent();
		logic [7:0] vec [5] = '{8'h0B, 8'h0C, 8'h0B, 8'h0B, 8'h0B};
		rq_t r;
		for (int i = 0; i < 5; i++) begin
			r = dflt(i[3:0], 16'h0048);
			{r.pres, r.xev, r.itab} = {1'h0, 1'h1, i == 4};
			fire(r, 1'h1, vec[i], {r.sel[15:2], r.itab, r.xev}, 1'h1);
			chk("contrib_ptr", {exc_contrib, exc_eip_sel}, {1'h1, (i == 4) ? 2'h1 : 2'h0});
		end
		$display("not-present test done");
	endtask : t_absent
	task automatic t_pre();
		rq_t r;
		logic bad;
		for (int i = 0; i < 20; i++) begin
			r = dflt(4'h5, {i[12:0] + 13'h8, 3'h0});
			r.xev = i[0];
			bad = 1'h1;
			case (i)
				0: r.tlim = 32'h0000_0066;
				1: {r.is32, r.tlim} = {1'h0, 32'h0000_002B};
				2: {r.interrupt_return_instr, r.busy} = 2'h2;
				3: {r.interrupt_return_instr, r.busy, r.sel[2]} = 3'h7;
				4: {r.interrupt_return_instr, r.busy, r.lim} = 3'h6;
				5: {r.src, r.typ} = {4'h6, 1'h0};
				6: {r.src, r.pres} = {4'h6, 1'h0};
				7: {r.src, r.lim} = {4'h7, 1'h0};
				8: {r.src, r.wr} = {4'h7, 1'h0};
				9: {r.src, r.dpriv} = {4'h7, 2'h1};
				10: {r.src, r.sel[1:0]} = {4'h7, 2'h1};
				11: {r.src, r.lim} = {4'h8, 1'h0};
				12: {r.src, r.ex} = {4'h8, 1'h0};
				13: {r.src, r.dpriv} = {4'h8, 2'h1};
				14: {r.src, r.conf, r.dpriv, r.cpriv} = {4'h8, 1'h1, 2'h2, 2'h1};
				15: {r.src, r.lim} = {4'h9, 1'h0};
				16: {r.src, r.rd} = {4'h9, 1'h0};
				17: bad = 1'h0; // limit exactly at the floor
				18: {bad, r.is32, r.tlim} = {2'h0, 32'h0000_002C};
				default: {bad, r.src, r.conf, r.cpriv} = {1'h0, 4'h8, 1'h1, 2'h1};
			endcase
			ts_pulse(3'h4);
			fire(r, bad, 8'h0A, {r.sel[15:2], 1'h0, r.xev}, bad);
			if (bad && r.src < 4'h7) chk("ptr_sel", exc_eip_sel, 2'h1);
			if (bad) chk("ctx_load", {exc_new_ctx, exc_load_all}, 2'h0);
			if (!bad) ts_pulse(3'h1);
		end
		$display("pre-commit test done");
	endtask : t_pre
	task automatic t_commit();
		rq_t r;
		@(posedge sys_clk);
		{ts_via_call, backlink_ok} <= 2'h2;
		ts_pulse(3'h4);
		fire(dflt(4'h5, 16'h0050), 1'h0, 8'h00, 16'h0000, 1'h0);
		ts_pulse(3'h2);
		@(negedge sys_clk);
		chk("committed", ts_committed, 1'h0);
		@(posedge sys_clk);
		backlink_ok <= 1'h1;
		ts_pulse(3'h2);
		@(negedge sys_clk);
		chk("committed", ts_committed, 1'h1);
		r = dflt(4'h8, 16'h0058);
		r.ex = 1'h0;
		fire(r, 1'h1, 8'h0A, 16'h0058, 1'h1);
		chk("post", {exc_eip_sel, exc_new_ctx, exc_load_all}, 4'hB);
		{r.src, r.ex, r.rd} = {4'h9, 2'h2};
		fire(r, 1'h0, 8'h00, 16'h0000, 1'h0);
		chk("seg_loaded", seg_loaded, 1'h1);
		ts_pulse(3'h1);
		@(negedge sys_clk);
		chk("committed", ts_committed, 1'h0);
		@(posedge sys_clk);
		{ts_via_call, backlink_ok} <= 2'h0;
		$display("commit test done");
	endtask : t_commit
	task automatic t_double();
		rq_t r;
		r = dflt(4'h0, 16'h0060);
		r.pres = 1'h0;
		@(posedge sys_clk);
		pf_delivering <= 1'h1;
		fire(r, 1'h1, 8'h08, 16'h0000, 1'h1);
		chk("restartable", exc_restartable, 1'h0);
		@(posedge sys_clk);
		pf_delivering <= 1'h0;
		fire(r, 1'h1, 8'h0B, 16'h0060, 1'h0);
		fire(r, 1'h1, 8'h08, 16'h0000, 1'h1);
		rd(exc_pkg::REG_LAST, 32'h0008_0000);
		rd(exc_pkg::REG_COUNT, exp_cnt);
		$display("double fault test done");
	endtask : t_double
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	// free-running clock
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// hang guard; the whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		{req_valid, ts_begin, ts_via_call, tr_loaded, backlink_ok, ts_end} = 6'h0;
		{pf_delivering, deliver_done, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
		put(dflt(4'h0, 16'h0000));
		rst_b = 1'h0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'h1;
		@(negedge sys_clk);
		t_reset();
		t_overrun();
		t_absent();
		t_pre();
		t_commit();
		t_double();
		end_sim();
	end
endmodule : tb_task_switch_segment_fault_checker
`default_nettype wire

// *** verilog/chk_if.sv ***
// descriptor check request and verdict between top and checker
// assumes both ends on sys_clk; purely combinational carrier
`timescale 1ns/1ps
`default_nettype none
interface chk_if;
	exc_pkg::src_t   src;
	logic [15:0]     sel;
	logic            present;
	logic            in_limit;
	logic            type_ok;
	logic            writable;
	logic            readable;
	logic            executable;
	logic            conforming;
	logic            busy;
	logic            is32;
	logic            interrupt_return_instr;
	logic [1:0]      descriptor_privilege_level;
	logic [1:0]      current_privilege_level;
	logic [31:0]     tss_limit;
	exc_pkg::fault_t fault;
	modport requester (output src, sel, present, in_limit, type_ok, writable, readable,
		executable, conforming, busy, is32, interrupt_return_instr, descriptor_privilege_level, current_privilege_level, tss_limit, input fault);
	modport judge (input src, sel, present, in_limit, type_ok, writable, readable,
		executable, conforming, busy, is32, interrupt_return_instr, descriptor_privilege_level, current_privilege_level, tss_limit, output fault);
endinterface : chk_if
`default_nettype wire

// *** verilog/contrib_tracker.sv ***
// remembers a contributory delivery in flight and flags a second one
// assumes raise and done are one-cycle pulses from the same clock
`timescale 1ns/1ps
`default_nettype none
module contrib_tracker (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// events
	input  wire logic contrib_raise,
	input  wire logic pf_delivering,
	input  wire logic deliver_done,
	// state
	output logic      in_contrib,
	output logic      make_double
);
	logic in_contrib_q;
	logic in_contrib_d;
	// a new raise beats a done in the same cycle
	assign in_contrib_d = contrib_raise ? 1'b1 : (deliver_done ? 1'b0 : in_contrib_q);
	assign make_double  = contrib_raise && (in_contrib_q || pf_delivering);
	assign in_contrib   = in_contrib_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) in_contrib_q <= 1'b0;
		else in_contrib_q <= in_contrib_d;
	end
endmodule : contrib_tracker
`default_nettype wire

// *** verilog/desc_checker.sv ***
// combinational descriptor validity checks, one verdict per request
// assumes the request fields are stable in the cycle they are read
`timescale 1ns/1ps
`default_nettype none
module desc_checker (
	chk_if.judge c
);
	wire [1:0] requested_privilege_level      = c.sel[exc_pkg::SEL_TI_BIT-1:0];
	wire [31:0] tss_min = c.is32 ? exc_pkg::TSS_MIN32 : exc_pkg::TSS_MIN16;
	// task-state segment: short limit, or bad selector on return
	wire tss_bad  = (c.tss_limit < tss_min) || (c.interrupt_return_instr && (c.sel[exc_pkg::SEL_TI_BIT] ||
		!c.in_limit || !c.busy));
	wire ldt_bad  = !c.in_limit || !c.type_ok || !c.present;
	wire ss_bad   = !c.in_limit || !c.writable || (c.descriptor_privilege_level != c.current_privilege_level) || (requested_privilege_level != c.current_privilege_level);
	wire cs_bad   = !c.in_limit || !c.executable ||
		(!c.conforming && (c.descriptor_privilege_level != c.current_privilege_level)) || (c.conforming && (c.descriptor_privilege_level > c.current_privilege_level));
	wire data_bad = !c.in_limit || !c.readable;
	// validity first, presence only on an otherwise valid descriptor
	always_comb begin
		c.fault = exc_pkg::F_NONE;
		case (c.src)
			exc_pkg::SRC_SEG_LOAD: if (!c.present) c.fault = exc_pkg::F_NP;
			exc_pkg::SRC_SS_LOAD:  if (!c.present) c.fault = exc_pkg::F_SS;
			exc_pkg::SRC_LOAD_LOCAL_TABLE_INSTR,
			exc_pkg::SRC_LTR,
			exc_pkg::SRC_GATE:     if (!c.present) c.fault = exc_pkg::F_NP;
			exc_pkg::SRC_TS_TSS:   c.fault = tss_bad ? exc_pkg::F_TS : (!c.present ? exc_pkg::F_NP : exc_pkg::F_NONE);
			exc_pkg::SRC_TS_LDT:   if (ldt_bad) c.fault = exc_pkg::F_TS;
			exc_pkg::SRC_TS_SS:    c.fault = ss_bad ? exc_pkg::F_TS : (!c.present ? exc_pkg::F_SS : exc_pkg::F_NONE);
			exc_pkg::SRC_TS_CS:    c.fault = cs_bad ? exc_pkg::F_TS : (!c.present ? exc_pkg::F_NP : exc_pkg::F_NONE);
			exc_pkg::SRC_TS_DATA:  c.fault = data_bad ? exc_pkg::F_TS : (!c.present ? exc_pkg::F_NP : exc_pkg::F_NONE);
			exc_pkg::SRC_COPRO:    c.fault = exc_pkg::F_OVR;
			default:               c.fault = exc_pkg::F_NONE;
		endcase
	end
endmodule : desc_checker
`default_nettype wire

// *** verilog/exc_pkg.sv ***
// exception vectors, check sources, error code layout and register map
// assumes a single core clock; no other package is needed
package exc_pkg;
	// vector numbers
	localparam logic [7:0] VEC_DF  = 8'h08;
	localparam logic [7:0] VEC_OVR = 8'h09;
	localparam logic [7:0] VEC_TS  = 8'h0A;
	localparam logic [7:0] VEC_NP  = 8'h0B;
	localparam logic [7:0] VEC_SS  = 8'h0C;
	localparam logic [7:0] VEC_GP  = 8'h0D;
	// least task-state segment limits
	localparam logic [31:0] TSS_MIN32 = 32'h0000_0067;
	localparam logic [31:0] TSS_MIN16 = 32'h0000_002C;
	// error code and selector fields
	localparam int EC_EXT_BIT = 0;
	localparam int EC_IDT_BIT = 1;
	localparam int SEL_TI_BIT = 2;
	localparam logic [15:0] EC_ZERO = 16'h0000;
	// register bus map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST   = 8'h08;
	localparam logic [7:0] REG_COUNT  = 8'h0C;
	localparam int CTRL_LEGACY_BIT = 0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// what asks for a descriptor check
	typedef enum logic [3:0] {
		SRC_SEG_LOAD = 4'h0, SRC_SS_LOAD = 4'h1, SRC_LOAD_LOCAL_TABLE_INSTR   = 4'h2,
		SRC_LTR      = 4'h3, SRC_GATE    = 4'h4, SRC_TS_TSS = 4'h5,
		SRC_TS_LDT   = 4'h6, SRC_TS_SS   = 4'h7, SRC_TS_CS  = 4'h8,
		SRC_TS_DATA  = 4'h9, SRC_COPRO   = 4'hA
	} src_t;
	typedef enum logic [2:0] {
		F_NONE = 3'h0, F_TS = 3'h1, F_NP = 3'h2,
		F_SS   = 3'h3, F_GP = 3'h4, F_OVR = 3'h5
	} fault_t;
	// which instruction the saved pointer names
	typedef enum logic [1:0] {
		EIP_FAULTING = 2'h0, EIP_INVOKER = 2'h1, EIP_NEW_TASK = 2'h2
	} eip_t;
	typedef enum logic [1:0] {
		TS_IDLE = 2'h0, TS_PRE = 2'h1, TS_POST = 2'h2
	} ts_state_t;
endpackage : exc_pkg

// *** verilog/task_switch_segment_fault_checker.sv ***
// exception selection for coprocessor overrun, invalid task state and
// segment-not-present, with error code and saved-pointer choice
// assumes every input comes from core logic on sys_clk, so none is synchronised
`timescale 1ns/1ps
`default_nettype none
module task_switch_segment_fault_checker (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// check request
	input  wire logic        req_valid,
	input  wire logic [3:0]  req_src,
	input  wire logic [15:0] req_sel,
	input  wire logic        req_present,
	input  wire logic        req_in_limit,
	input  wire logic        req_type_ok,
	input  wire logic        req_writable,
	input  wire logic        req_readable,
	input  wire logic        req_executable,
	input  wire logic        req_conforming,
	input  wire logic [1:0]  req_dpl,
	input  wire logic [1:0]  cur_cpl,
	input  wire logic        req_ext_event,
	input  wire logic        req_idt_ref,
	// task-state segment facts
	input  wire logic [31:0] tss_limit,
	input  wire logic        tss_is32,
	input  wire logic        tss_busy,
	// task switch progress
	input  wire logic        ts_begin,
	input  wire logic        ts_interrupt_return_instr,
	input  wire logic        ts_via_call,
	input  wire logic        tr_loaded,
	input  wire logic        backlink_ok,
	input  wire logic        ts_end,
	// delivery tracking
	input  wire logic        pf_delivering,
	input  wire logic        deliver_done,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wr_data,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	output logic      [31:0] reg_rd_data,
	// exception out
	output logic             exc_valid,
	output logic      [7:0]  exc_vector,
	output logic      [15:0] exc_err_code,
	output logic             exc_err_push,
	output logic      [1:0]  exc_eip_sel,
	output logic             exc_new_ctx,
	output logic             exc_load_all,
	output logic             exc_restartable,
	output logic             exc_contrib,
	// task switch status
	output logic             seg_loaded,
	output logic             ts_committed
);
	// carrier to the checker
	chk_if chk ();

	assign chk.src        = exc_pkg::src_t'(req_src);
	assign chk.sel        = req_sel;
	assign chk.present    = req_present;
	assign chk.in_limit   = req_in_limit;
	assign chk.type_ok    = req_type_ok;
	assign chk.writable   = req_writable;
	assign chk.readable   = req_readable;
	assign chk.executable = req_executable;
	assign chk.conforming = req_conforming;
	assign chk.busy       = tss_busy;
	assign chk.is32       = tss_is32;
	assign chk.interrupt_return_instr       = ts_interrupt_return_instr;
	assign chk.descriptor_privilege_level        = req_dpl;
	assign chk.current_privilege_level        = cur_cpl;
	assign chk.tss_limit  = tss_limit;

	// limit, privilege, type and presence checks per source
	desc_checker u_chk (
		.c (chk.judge)
	);

	// state
	exc_pkg::ts_state_t ts_q;
	exc_pkg::ts_state_t ts_d;
	logic        viol_q;
	logic        viol_d;
	logic        legacy_q;
	logic        legacy_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [7:0]  last_vec_q;
	logic [15:0] last_code_q;
	logic        exc_valid_q;
	logic [7:0]  exc_vector_q;
	logic [15:0] exc_err_code_q;
	logic        exc_err_push_q;
	logic [1:0]  exc_eip_sel_q;
	logic        exc_new_ctx_q;
	logic        exc_load_all_q;
	logic        exc_restartable_q;
	logic        exc_contrib_q;
	logic        seg_loaded_q;
	logic        committed_q;
	logic [31:0] rd_data_q;

	// request classification
	wire ts_src   = (req_src >= exc_pkg::SRC_TS_TSS) && (req_src <= exc_pkg::SRC_TS_DATA);
	wire seg_src  = (req_src >= exc_pkg::SRC_TS_SS) && (req_src <= exc_pkg::SRC_TS_DATA);
	wire in_ts    = (ts_q != exc_pkg::TS_IDLE);
	wire post     = (ts_q == exc_pkg::TS_POST);
	wire gate_src = (req_src == exc_pkg::SRC_GATE);

	// after a violation the remaining segment loads go unchecked
	wire suppress = in_ts && viol_q && seg_src;
	wire fault_hit = req_valid && (chk.fault != exc_pkg::F_NONE) && !suppress;

	wire is_ts  = (chk.fault == exc_pkg::F_TS);
	wire is_np  = (chk.fault == exc_pkg::F_NP);
	wire is_ss  = (chk.fault == exc_pkg::F_SS);
	wire is_ovr = (chk.fault == exc_pkg::F_OVR);

	// legacy cores keep the overrun vector, current ones map it to protection
	wire ovr_gp = is_ovr && !legacy_q;
	wire contrib_raise = fault_hit && (is_ts || is_np || is_ss || ovr_gp);

	// double fault tracking across delivery
	logic in_contrib;
	logic make_double;
	contrib_tracker u_trk (
		.sys_clk       (sys_clk),
		.rst_b         (rst_b),
		.contrib_raise (contrib_raise),
		.pf_delivering (pf_delivering),
		.deliver_done  (deliver_done),
		.in_contrib    (in_contrib),
		.make_double   (make_double)
	);

	// vector selection
	logic [7:0] vec_w;
	always_comb begin
		vec_w = exc_pkg::VEC_GP;
		if (make_double) vec_w = exc_pkg::VEC_DF;
		else if (is_ts) vec_w = exc_pkg::VEC_TS;
		else if (is_np) vec_w = exc_pkg::VEC_NP;
		else if (is_ss) vec_w = exc_pkg::VEC_SS;
		else if (is_ovr) vec_w = legacy_q ? exc_pkg::VEC_OVR : exc_pkg::VEC_GP;
		else vec_w = exc_pkg::VEC_GP;
	end

	// error code: selector index and table bit, then interrupt-table and external flags
	wire idt_w = is_np && req_idt_ref;
	wire [15:0] code_w = {req_sel[15:exc_pkg::SEL_TI_BIT], idt_w, req_ext_event};
	wire [15:0] code_sel = make_double ? exc_pkg::EC_ZERO : code_w;
	// overrun in legacy mode pushes nothing
	wire push_w = make_double || !(is_ovr && legacy_q);

	// saved instruction pointer choice
	logic [1:0] eip_w;
	always_comb begin
		eip_w = exc_pkg::EIP_FAULTING;
		if (is_ovr) eip_w = exc_pkg::EIP_FAULTING;
		else if (gate_src && is_np) eip_w = exc_pkg::EIP_INVOKER;
		else if (ts_src && seg_src && (is_np || is_ss)) eip_w = exc_pkg::EIP_NEW_TASK;
		else if (ts_src && is_ts) eip_w = post ? exc_pkg::EIP_NEW_TASK : exc_pkg::EIP_INVOKER;
		else if (ts_src) eip_w = post ? exc_pkg::EIP_NEW_TASK : exc_pkg::EIP_INVOKER;
		else eip_w = exc_pkg::EIP_FAULTING;
	end

	// context and state change follow the commit point
	wire new_ctx_w  = ts_src && post;
	wire load_all_w = ts_src && post;
	// a legacy-mode overrun leaves state undefined; a double fault is an abort too
	wire restart_w  = !(is_ovr && legacy_q) && !make_double;

	// commit once the task register holds the new selector and, for a switch by call, the link is set
	wire commit = tr_loaded && (!ts_via_call || backlink_ok);

	// task switch sequencer
	always_comb begin
		ts_d = ts_q;
		case (ts_q)
			exc_pkg::TS_IDLE: begin
				if (ts_begin) ts_d = exc_pkg::TS_PRE;
			end
			exc_pkg::TS_PRE: begin
				// a pre-commit fault abandons the switch with no state change
				if (fault_hit && ts_src) ts_d = exc_pkg::TS_IDLE;
				else if (commit) ts_d = exc_pkg::TS_POST;
				else if (ts_end) ts_d = exc_pkg::TS_IDLE;
			end
			exc_pkg::TS_POST: begin
				if (ts_end) ts_d = exc_pkg::TS_IDLE;
			end
			default: ts_d = exc_pkg::TS_IDLE;
		endcase
	end

	// violation memory; cleared only when a new switch starts
	always_comb begin
		viol_d = viol_q;
		if (ts_begin) viol_d = 1'b0;
		if (fault_hit && seg_src && in_ts) viol_d = 1'b1;
	end

	// register writes and the exception counter
	wire wr_ctrl = reg_wr_en && (reg_addr == exc_pkg::REG_CTRL);
	wire wr_cnt  = reg_wr_en && (reg_addr == exc_pkg::REG_COUNT);
	assign legacy_d = wr_ctrl ? reg_wr_data[exc_pkg::CTRL_LEGACY_BIT] : legacy_q;
	// a counted exception beats a software clear in the same cycle
	assign count_d  = fault_hit ? (count_q + 16'h0001) : (wr_cnt ? 16'h0000 : count_q);

	// read decode; unmapped addresses read zero
	logic [31:0] rd_w;
	always_comb begin
		rd_w = exc_pkg::RD_ZERO;
		case (reg_addr)
			exc_pkg::REG_CTRL:   rd_w = {31'h0000_0000, legacy_q};
			exc_pkg::REG_STATUS: rd_w = {27'h000_0000, in_contrib, viol_q, post, in_ts, ts_committed};
			exc_pkg::REG_LAST:   rd_w = {8'h00, last_vec_q, last_code_q};
			exc_pkg::REG_COUNT:  rd_w = {16'h0000, count_q};
			default:             rd_w = exc_pkg::RD_ZERO;
		endcase
	end

	// control state
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_q     <= exc_pkg::TS_IDLE;
			viol_q   <= 1'b0;
			legacy_q <= 1'b0;
			count_q  <= 16'h0000;
			committed_q <= 1'b0;
		end else begin
			committed_q <= (ts_d == exc_pkg::TS_POST);
			ts_q     <= ts_d;
			viol_q   <= viol_d;
			legacy_q <= legacy_d;
			count_q  <= count_d;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) rd_data_q <= exc_pkg::RD_ZERO;
		else rd_data_q <= reg_rd_en ? rd_w : exc_pkg::RD_ZERO;
	end

	// last exception capture for software
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_vec_q  <= 8'h00;
			last_code_q <= 16'h0000;
		end else if (fault_hit) begin
			last_vec_q  <= vec_w;
			last_code_q <= code_sel;
		end
	end

	// exception strobe, one cycle after the request
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			exc_valid_q <= 1'b0;
			seg_loaded_q <= 1'b0;
		end else begin
			exc_valid_q  <= fault_hit;
			seg_loaded_q <= req_valid && seg_src && in_ts;
		end
	end

	// exception payload, held until the next exception
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			exc_vector_q      <= 8'h00;
			exc_err_code_q    <= 16'h0000;
			exc_err_push_q    <= 1'b0;
			exc_eip_sel_q     <= exc_pkg::EIP_FAULTING;
			exc_new_ctx_q     <= 1'b0;
			exc_load_all_q    <= 1'b0;
			exc_restartable_q <= 1'b1;
			exc_contrib_q     <= 1'b0;
		end else if (fault_hit) begin
			exc_vector_q      <= vec_w;
			exc_err_code_q    <= code_sel;
			exc_err_push_q    <= push_w;
			exc_eip_sel_q     <= eip_w;
			exc_new_ctx_q     <= new_ctx_w;
			exc_load_all_q    <= load_all_w;
			exc_restartable_q <= restart_w;
			exc_contrib_q     <= contrib_raise && !make_double;
		end
	end

	// committed flag has its own flop, mirroring the post-commit state
	assign ts_committed    = committed_q;
	assign reg_rd_data     = rd_data_q;
	assign exc_valid       = exc_valid_q;
	assign exc_vector      = exc_vector_q;
	assign exc_err_code    = exc_err_code_q;
	assign exc_err_push    = exc_err_push_q;
	assign exc_eip_sel     = exc_eip_sel_q;
	assign exc_new_ctx     = exc_new_ctx_q;
	assign exc_load_all    = exc_load_all_q;
	assign exc_restartable = exc_restartable_q;
	assign exc_contrib     = exc_contrib_q;
	assign seg_loaded      = seg_loaded_q;
endmodule : task_switch_segment_fault_checker
`default_nettype wire
